// ==== meirq_pkg.sv ====
// Constants and types for the metering status and calibration mode block
// Behaviour
// - Zero-cross config bit 1 drives zero-crossing signal onto port 1 pin 2
// - Zero-cross config bit 0 drives it onto port 0 pin 5; both reset 0
// - Bits 5:4 pick input A (01), input B (10), else tamper logic
// - Calibration control bit 3 grounds the voltage input
// - Calibration control bit 2 grounds the current input
// - Low status bit 7 shows any enabled flag set; clears itself
// - Low status bit 5 sets on fault mode change in selected direction
// - Low status bits 4 and 3 set on reactive and active sign change
// - Low status bit 2 sets on apparent no-load or rms no-load entry
// - Low status bits 1 and 0 set on reactive and active no-load
// - Mid status bits 7 and 6 set on every pulse-output pulse
// - Mid status bits 5,4,3 set on apparent, reactive, active overflow
// - Mid status bits 2,1,0 set on apparent, reactive, active half full
// - High status bit 7 sets at the end of hardware or software reset
// - High status bit 5 sets when a new waveform sample is loaded
// - High status bits 4 and 3 set on current and voltage peak
// - High status bit 2 sets when line-cycle accumulation completes
// - High status bit 1 sets on zero-crossing timeout
// - High status bit 0 sets on each voltage zero crossing
// - Any enabled flag that is set raises the pending interrupt
// - Accumulation bit 6: 0 flags fault entry, 1 flags return to normal
// - Accumulation bit 4: 0 flags positive-to-negative, 1 the reverse
package meirq_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] MEIRQ_IDX_ACCUM_CFG = 8'h0F;
	localparam logic [7:0] MEIRQ_IDX_ZX_OUT_CFG = 8'h2B;
	localparam logic [7:0] MEIRQ_IDX_CAL_CTRL = 8'h3D;
	localparam logic [7:0] MEIRQ_IDX_EN_LOW = 8'hD9;
	localparam logic [7:0] MEIRQ_IDX_EN_MID = 8'hDA;
	localparam logic [7:0] MEIRQ_IDX_EN_HIGH = 8'hDB;
	localparam logic [7:0] MEIRQ_IDX_ST_LOW = 8'hDC;
	localparam logic [7:0] MEIRQ_IDX_ST_MID = 8'hDD;
	localparam logic [7:0] MEIRQ_IDX_ST_HIGH = 8'hDE;

	// Field positions
	localparam int MEIRQ_ZX_P12_BIT = 1;
	localparam int MEIRQ_ZX_P05_BIT = 0;
	localparam int MEIRQ_CAL_SEL_LSB = 4;
	localparam int MEIRQ_CAL_VGND_BIT = 3;
	localparam int MEIRQ_CAL_IGND_BIT = 2;
	localparam int MEIRQ_ACC_FAULT_BIT = 6;
	localparam int MEIRQ_ACC_VAR_BIT = 5;
	localparam int MEIRQ_ACC_AP_BIT = 4;
	localparam int MEIRQ_SUMMARY_BIT = 7;
	localparam int MEIRQ_RESET_FLAG_BIT = 7;

	// Writable masks and reset values
	localparam logic [7:0] MEIRQ_ZX_MASK = 8'h03;
	localparam logic [7:0] MEIRQ_CAL_MASK = 8'h3C;
	localparam logic [7:0] MEIRQ_ACC_MASK = 8'hFF;
	localparam logic [7:0] MEIRQ_LOWHIGH_MASK = 8'h3F;
	localparam logic [7:0] MEIRQ_HIGH_ST_MASK = 8'hBF;
	localparam logic [7:0] MEIRQ_RST_VAL = 8'h00;

	// Current channel select codes
	localparam logic [1:0] MEIRQ_SEL_A = 2'h1;
	localparam logic [1:0] MEIRQ_SEL_B = 2'h2;

	// Metering events from the datapath, all on pclk
	typedef struct packed {
		logic fault_mode;
		logic reactive_neg;
		logic active_neg;
		logic apparent_noload;
		logic irms_noload_enter;
		logic reactive_noload;
		logic active_noload;
		logic pulse_out_two;
		logic pulse_out_one;
		logic apparent_energy_overflow;
		logic reactive_energy_overflow;
		logic active_energy_overflow;
		logic apparent_energy_half;
		logic reactive_energy_half;
		logic active_energy_half;
		logic soft_reset_done;
		logic waveform_sample_ready;
		logic current_peak_flag;
		logic voltage_peak_flag;
		logic line_cycle_done;
		logic zero_cross_timeout;
		logic zero_cross_detect;
	} meirq_events_type;

	// Analog front-end steering
	typedef struct packed {
		logic use_input_b;
		logic auto_select;
		logic voltage_input_ground;
		logic current_input_ground;
	} meirq_afe_type;

	// Whole state of the block
	typedef struct packed {
		logic [7:0] zx_cfg;
		logic [7:0] cal_ctrl;
		logic [7:0] accum_cfg;
		logic [7:0] en_low;
		logic [7:0] en_mid;
		logic [7:0] en_high;
		logic [7:0] st_low;
		logic [7:0] st_mid;
		logic [7:0] st_high;
		logic fault_prev;
		logic reactive_prev;
		logic active_prev;
		logic reset_seen;
		logic [31:0] prdata;
		logic pslverr;
	} meirq_state_type;

endpackage

// ==== meirq_top.sv ====
// Metering status flags, summary interrupt and calibration mode registers
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module meirq_top
	import meirq_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire meirq_events_type events,
	input wire logic zero_cross_signal,
	input wire logic tamper_picks_b,
	output logic zero_cross_out_port1,
	output logic zero_cross_out_port1_oe_n,
	output logic zero_cross_out_port0,
	output logic zero_cross_out_port0_oe_n,
	output meirq_afe_type afe,
	output logic current_channel_b,
	output logic meter_irq_pending
);

	meirq_state_type s_q;
	meirq_state_type s_d;

	logic setup_phase;
	logic access_phase;
	logic wr_en;
	logic [7:0] idx;
	logic addr_ok;
	logic [7:0] wbyte;
	logic [7:0] clr_low;
	logic [7:0] clr_mid;
	logic [7:0] clr_high;
	logic [7:0] set_low;
	logic [7:0] set_mid;
	logic [7:0] set_high;
	logic fault_edge;
	logic reactive_edge;
	logic active_edge;
	logic summary;

	// Index of a word-aligned address, or all ones when misaligned or past the 8-bit index range
	function automatic logic [7:0] word_index(
		input logic [ADDR_W-1:0] a
	);
		logic [ADDR_W-1:0] w;
		w = a >> 2;
		if (a[1:0] != 2'h0 || (w >> 8) != '0) begin
			word_index = 8'hFF;
		end else begin
			word_index = w[7:0];
		end
	endfunction

	// True for every index that holds a register
	function automatic logic is_mapped(input logic [7:0] i);
		case (i)
			MEIRQ_IDX_ACCUM_CFG,
			MEIRQ_IDX_ZX_OUT_CFG,
			MEIRQ_IDX_CAL_CTRL,
			MEIRQ_IDX_EN_LOW,
			MEIRQ_IDX_EN_MID,
			MEIRQ_IDX_EN_HIGH,
			MEIRQ_IDX_ST_LOW,
			MEIRQ_IDX_ST_MID,
			MEIRQ_IDX_ST_HIGH: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = 1'b0;
			end
		endcase
	endfunction

	// Edge of a level in the direction picked by a select bit
	function automatic logic dir_edge(
		input logic prev,
		input logic now,
		input logic sel
	);
		if (sel) begin
			dir_edge = prev & ~now;
		end else begin
			dir_edge = ~prev & now;
		end
	endfunction

	// Read value of one register
	function automatic logic [7:0] read_reg(
		input logic [7:0] i,
		input meirq_state_type st,
		input logic summ
	);
		logic [7:0] v;
		v = 8'h00;
		case (i)
			MEIRQ_IDX_ACCUM_CFG: begin
				v = st.accum_cfg;
			end
			MEIRQ_IDX_ZX_OUT_CFG: begin
				v = st.zx_cfg;
			end
			MEIRQ_IDX_CAL_CTRL: begin
				v = st.cal_ctrl;
			end
			MEIRQ_IDX_EN_LOW: begin
				v = st.en_low;
			end
			MEIRQ_IDX_EN_MID: begin
				v = st.en_mid;
			end
			MEIRQ_IDX_EN_HIGH: begin
				v = st.en_high;
			end
			MEIRQ_IDX_ST_LOW: begin
				v = st.st_low;
				v[MEIRQ_SUMMARY_BIT] = summ;
			end
			MEIRQ_IDX_ST_MID: begin
				v = st.st_mid;
			end
			MEIRQ_IDX_ST_HIGH: begin
				v = st.st_high;
			end
			default: begin
				v = 8'h00;
			end
		endcase
		read_reg = v;
	endfunction

	// Zero wait states; data was fetched in the setup cycle
	assign pready = 1'b1;
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign idx = word_index(paddr);
	assign addr_ok = is_mapped(idx);
	assign wr_en = access_phase & pwrite & addr_ok & pstrb[0];
	assign wbyte = pwdata[7:0];

	// Direction-selected sign and fault changes
	assign fault_edge = dir_edge(s_q.fault_prev, events.fault_mode,
		s_q.accum_cfg[MEIRQ_ACC_FAULT_BIT]);
	assign reactive_edge = dir_edge(s_q.reactive_prev, events.reactive_neg,
		s_q.accum_cfg[MEIRQ_ACC_VAR_BIT]);
	assign active_edge = dir_edge(s_q.active_prev, events.active_neg,
		s_q.accum_cfg[MEIRQ_ACC_AP_BIT]);

	// Event sets, one vector per status register
	always_comb begin
		set_low = 8'h00;
		set_low[5] = fault_edge;
		set_low[4] = reactive_edge;
		set_low[3] = active_edge;
		set_low[2] = events.apparent_noload | events.irms_noload_enter;
		set_low[1] = events.reactive_noload;
		set_low[0] = events.active_noload;
	end

	always_comb begin
		set_mid = 8'h00;
		// Set regardless of whether the pulse pins are enabled
		set_mid[7] = events.pulse_out_two;
		set_mid[6] = events.pulse_out_one;
		set_mid[5] = events.apparent_energy_overflow;
		set_mid[4] = events.reactive_energy_overflow;
		set_mid[3] = events.active_energy_overflow;
		set_mid[2] = events.apparent_energy_half;
		set_mid[1] = events.reactive_energy_half;
		set_mid[0] = events.active_energy_half;
	end

	always_comb begin
		set_high = 8'h00;
		// First cycle after release, or a software reset finishing
		set_high[7] = ~s_q.reset_seen | events.soft_reset_done;
		set_high[5] = events.waveform_sample_ready;
		set_high[4] = events.current_peak_flag;
		set_high[3] = events.voltage_peak_flag;
		set_high[2] = events.line_cycle_done;
		set_high[1] = events.zero_cross_timeout;
		set_high[0] = events.zero_cross_detect;
	end

	// Write-one-to-clear on the status registers
	always_comb begin
		clr_low = 8'h00;
		clr_mid = 8'h00;
		clr_high = 8'h00;
		if (wr_en && idx == MEIRQ_IDX_ST_LOW) begin
			clr_low = wbyte & MEIRQ_LOWHIGH_MASK;
		end
		if (wr_en && idx == MEIRQ_IDX_ST_MID) begin
			clr_mid = wbyte;
		end
		if (wr_en && idx == MEIRQ_IDX_ST_HIGH) begin
			clr_high = wbyte & MEIRQ_HIGH_ST_MASK;
		end
	end

	// Summary tracks the live flags, so it drops as soon as they clear
	assign summary = |(s_q.st_low & s_q.en_low & MEIRQ_LOWHIGH_MASK)
		| |(s_q.st_mid & s_q.en_mid)
		| |(s_q.st_high & s_q.en_high & MEIRQ_LOWHIGH_MASK);

	always_comb begin
		s_d = s_q;
		s_d.fault_prev = events.fault_mode;
		s_d.reactive_prev = events.reactive_neg;
		s_d.active_prev = events.active_neg;
		s_d.reset_seen = 1'b1;

		// Sticky flags; a set in the clearing cycle wins
		s_d.st_low = ((s_q.st_low & ~clr_low) | set_low)
			& MEIRQ_LOWHIGH_MASK;
		s_d.st_mid = (s_q.st_mid & ~clr_mid) | set_mid;
		s_d.st_high = ((s_q.st_high & ~clr_high) | set_high)
			& MEIRQ_HIGH_ST_MASK;

		if (wr_en) begin
			case (idx)
				MEIRQ_IDX_ACCUM_CFG: begin
					s_d.accum_cfg = wbyte & MEIRQ_ACC_MASK;
				end
				MEIRQ_IDX_ZX_OUT_CFG: begin
					s_d.zx_cfg = wbyte & MEIRQ_ZX_MASK;
				end
				MEIRQ_IDX_CAL_CTRL: begin
					// Reserved bits dropped; software should write them zero
					s_d.cal_ctrl = wbyte & MEIRQ_CAL_MASK;
				end
				MEIRQ_IDX_EN_LOW: begin
					s_d.en_low = wbyte & MEIRQ_LOWHIGH_MASK;
				end
				MEIRQ_IDX_EN_MID: begin
					s_d.en_mid = wbyte;
				end
				MEIRQ_IDX_EN_HIGH: begin
					s_d.en_high = wbyte & MEIRQ_LOWHIGH_MASK;
				end
				default: begin
					s_d.zx_cfg = s_q.zx_cfg;
				end
			endcase
		end

		// Answer is latched in setup so prdata comes from a flop
		if (setup_phase) begin
			s_d.pslverr = ~is_mapped(word_index(paddr));
			s_d.prdata = 32'h0000_0000;
			if (!pwrite) begin
				s_d.prdata[7:0] = read_reg(word_index(paddr), s_q, summary);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.zx_cfg <= MEIRQ_RST_VAL;
			s_q.cal_ctrl <= MEIRQ_RST_VAL;
			s_q.accum_cfg <= MEIRQ_RST_VAL;
			s_q.en_low <= MEIRQ_RST_VAL;
			s_q.en_mid <= MEIRQ_RST_VAL;
			s_q.en_high <= MEIRQ_RST_VAL;
			s_q.st_low <= MEIRQ_RST_VAL;
			s_q.st_mid <= MEIRQ_RST_VAL;
			s_q.st_high <= MEIRQ_RST_VAL;
			s_q.fault_prev <= 1'b0;
			s_q.reactive_prev <= 1'b0;
			s_q.active_prev <= 1'b0;
			s_q.reset_seen <= 1'b0;
			s_q.prdata <= 32'h0000_0000;
			s_q.pslverr <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr & access_phase;

	// Zero-crossing pin drivers; enable is active low
	assign zero_cross_out_port1 = zero_cross_signal
		& s_q.zx_cfg[MEIRQ_ZX_P12_BIT];
	assign zero_cross_out_port1_oe_n = ~s_q.zx_cfg[MEIRQ_ZX_P12_BIT];
	assign zero_cross_out_port0 = zero_cross_signal
		& s_q.zx_cfg[MEIRQ_ZX_P05_BIT];
	assign zero_cross_out_port0_oe_n = ~s_q.zx_cfg[MEIRQ_ZX_P05_BIT];

	// Current channel routing and input grounding
	always_comb begin
		afe.use_input_b = 1'b0;
		afe.auto_select = 1'b0;
		case (s_q.cal_ctrl[MEIRQ_CAL_SEL_LSB +: 2])
			MEIRQ_SEL_A: begin
				afe.use_input_b = 1'b0;
			end
			MEIRQ_SEL_B: begin
				afe.use_input_b = 1'b1;
			end
			default: begin
				afe.use_input_b = tamper_picks_b;
				afe.auto_select = 1'b1;
			end
		endcase
		afe.voltage_input_ground = s_q.cal_ctrl[MEIRQ_CAL_VGND_BIT];
		afe.current_input_ground = s_q.cal_ctrl[MEIRQ_CAL_IGND_BIT];
	end

	assign current_channel_b = afe.use_input_b;
	assign meter_irq_pending = summary;

endmodule

// ==== meirq_checker.sv ====
// Port assertions for the metering status block
`timescale 1ns/10ps
module meirq_checker
	import meirq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire meirq_events_type events,
	input wire logic zero_cross_signal,
	input wire logic tamper_picks_b,
	input wire logic zero_cross_out_port1,
	input wire logic zero_cross_out_port1_oe_n,
	input wire logic zero_cross_out_port0,
	input wire logic zero_cross_out_port0_oe_n,
	input wire meirq_afe_type afe,
	input wire logic current_channel_b,
	input wire logic meter_irq_pending
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	assign wr = psel && penable && pwrite && pstrb[0];
	AST_PORT1: assert property (
		zero_cross_out_port1 == (zero_cross_signal && !zero_cross_out_port1_oe_n))
		else $error("port1 pin wrong");
	AST_PORT0: assert property (
		zero_cross_out_port0 == (zero_cross_signal && !zero_cross_out_port0_oe_n))
		else $error("port0 pin wrong");
	AST_ZXCFG: assert property (wr && paddr == 12'h0AC |=>
		{zero_cross_out_port1_oe_n, zero_cross_out_port0_oe_n} ==
		~$past(pwdata[1:0])) else $error("pin enable wrong");
	AST_CALGND: assert property (wr && paddr == 12'h0F4 |=>
		{afe.voltage_input_ground, afe.current_input_ground} ==
		$past(pwdata[3:2])) else $error("ground wrong");
	AST_SEL: assert property (wr && paddr == 12'h0F4 |=>
		afe.auto_select == ($past(pwdata[5]) == $past(pwdata[4])))
		else $error("auto select wrong");
	AST_CHAN: assert property (afe.auto_select |->
		current_channel_b == tamper_picks_b) else $error("channel wrong");
	// A level dropping back to zero still counts, hence two cycles back
	AST_IRQRISE: assert property ($rose(meter_irq_pending) |->
		$past(events) != '0 || $past(events, 2) != '0 || $past(wr))
		else $error("irq rose alone");
	AST_READY: assert property (psel && penable |-> pready)
		else $error("no ready in access");
	AST_ERRPHASE: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	AST_IRQFALL: assert property ($fell(meter_irq_pending) |->
		$past(wr)) else $error("irq fell alone");
	COV_IRQ: cover property ($rose(meter_irq_pending));
	COV_ZX: cover property (wr && paddr == 12'h0AC);
	COV_CAL: cover property (wr && paddr == 12'h0F4);
endmodule

bind meirq_top meirq_checker i_meirq_checker(.*);

// ==== meirq_host.sv ====
// Bus master model for the core that owns the registers
`timescale 1ns/10ps
module meirq_host (
	input wire logic pclk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	int tmo;
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		tmo = 0;
	end
	task xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s = 4'hF);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 8);
		if (!pready)
			tmo++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ==== test_meirq_top.sv ====
// Self-checking bench for the metering status block
`timescale 1ns/10ps
module test_meirq_top;
	import meirq_pkg::*;
	logic pclk, presetn, zsig, tamper, psel, penable, pwrite, pready;
	logic pslverr, irq, p1, p1n, p0, p0n, chb, b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rs;
	logic [3:0] pstrb;
	meirq_events_type ev;
	meirq_afe_type afe;
	logic [8:0] q[$];
	int fails, n_tests;
	meirq_host i_meirq_host(.pclk(pclk), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb));
	meirq_top i_meirq_top(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.events(ev), .zero_cross_signal(zsig), .tamper_picks_b(tamper),
		.zero_cross_out_port1(p1), .zero_cross_out_port1_oe_n(p1n),
		.zero_cross_out_port0(p0), .zero_cross_out_port0_oe_n(p0n),
		.afe(afe), .current_channel_b(chb), .meter_irq_pending(irq));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task chk(input logic [8:0] got, input logic [8:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task summarize;
		fails += i_meirq_host.tmo;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		i_meirq_host.xfer(1'b1, {2'h0, idx, 2'h0}, d);
		if (i_meirq_host.tmo > 0)
			summarize();
	endtask
	task rd(input logic [7:0] idx, input logic [8:0] e);
		q.push_back(e);
		i_meirq_host.xfer(1'b0, {2'h0, idx, 2'h0}, 8'h00);
		if (i_meirq_host.tmo > 0)
			summarize();
	endtask
	task clr;
		for (int i = 0; i < 3; i++)
			wr(MEIRQ_IDX_ST_LOW + i[7:0], 8'hFF);
	endtask
	task pulse(input meirq_events_type e);
		@(posedge pclk) ev <= e;
		@(posedge pclk) ev <= '0;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Read data stands until the next setup, so sampling here is safe
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (q.size() == 0)
				chk(9'h1FF, 9'h000);
			else
				chk({pslverr, prdata[7:0]}, q.pop_front());
		end
	end
	initial begin
		presetn = 1'b0;
		{zsig, tamper} = 2'h0;
		ev = '0;
		rs = 32'h0000ED86;
		fails = 0;
		n_tests = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(MEIRQ_IDX_ST_HIGH, 9'h080);
		wr(MEIRQ_IDX_ST_HIGH, 8'hFF);
		rd(MEIRQ_IDX_ST_HIGH, 9'h000);
		rd(8'h01, 9'h100);
		// Byte lane 0 strobe low: the write must be ignored
		i_meirq_host.xfer(1'b1, 12'h0AC, 8'h03, 4'hE);
		rd(MEIRQ_IDX_ZX_OUT_CFG, 9'h000);
		q.push_back(9'h100);
		i_meirq_host.xfer(1'b0, 12'h37A, 8'h00);
		$display("reset flag test done");
		for (int k = 0; k < 6; k++) begin
			rs = xs(rs);
			pulse({3'h0, rs[18:0]});
			rd(MEIRQ_IDX_ST_MID, {1'b0, rs[14:7]});
			rd(MEIRQ_IDX_ST_HIGH, {1'b0, rs[6], 1'b0, rs[5:0]});
			rd(MEIRQ_IDX_ST_LOW, {6'h00, rs[18] | rs[17], rs[16:15]});
			clr();
		end
		$display("event flag test done");
		wr(MEIRQ_IDX_ACCUM_CFG, 8'h70);
		@(posedge pclk) ev <= 22'h380000;
		rd(MEIRQ_IDX_ST_LOW, 9'h000);
		@(posedge pclk) ev <= '0;
		rd(MEIRQ_IDX_ST_LOW, 9'h038);
		clr();
		wr(MEIRQ_IDX_ACCUM_CFG, 8'h00);
		@(posedge pclk) ev <= 22'h380000;
		rd(MEIRQ_IDX_ST_LOW, 9'h038);
		@(posedge pclk) ev <= '0;
		clr();
		$display("sign test done");
		wr(MEIRQ_IDX_EN_HIGH, 8'h01);
		pulse(22'h000001);
		repeat (3) @(negedge pclk);
		chk({8'h00, irq}, 9'h001);
		rd(MEIRQ_IDX_ST_LOW, 9'h080);
		wr(MEIRQ_IDX_ST_HIGH, 8'h01);
		@(negedge pclk) chk({8'h00, irq}, 9'h000);
		wr(MEIRQ_IDX_EN_HIGH, 8'h00);
		pulse(22'h000001);
		@(negedge pclk) chk({8'h00, irq}, 9'h000);
		$display("interrupt test done");
		for (int c = 0; c < 16; c++) begin
			rs = xs(rs);
			@(posedge pclk) zsig <= rs[0];
			tamper <= rs[1];
			wr(MEIRQ_IDX_ZX_OUT_CFG, {6'h00, c[1:0]});
			wr(MEIRQ_IDX_CAL_CTRL, {2'h0, c[3:0], 2'h0});
			b = (c[3:2] == 2'h2) || (c[3] == c[2] && rs[1]);
			@(negedge pclk);
			chk({p1n, p0n, p1, p0, chb, afe}, {~c[1:0], c[1:0] & {2{rs[0]}},
				b, b, c[3] == c[2], c[1:0]});
			rd(MEIRQ_IDX_CAL_CTRL, {3'h0, c[3:0], 2'h0});
		end
		$display("pin test done");
		summarize();
	end
endmodule
